// *** tws_line_model.sv ***
// Behavioural model of the other parties on the two-wire lines
`timescale 1ns/1ns
module tws_line_model (
  // Bus lines, pulled up when released
  output logic scl,
  output logic sda
);
  // Lines rest high on their pull-ups, SCL stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start by another master: SDA falls while SCL is high
  task automatic start_c();
    #3;
    #32 sda = 1'b0;
    #32 scl = 1'b0;
    #32;
  endtask
  // Stop: SCL low first so that SDA only rises while SCL is high
  task automatic stop_c();
    #3;
    #32 scl = 1'b0;
    #32 sda = 1'b0;
    #32 scl = 1'b1;
    #32 sda = 1'b1;
    #32;
  endtask
  // Start directly followed by Stop with SCL high throughout
  task automatic fault_c();
    #3;
    #32 sda = 1'b0;
    #32 sda = 1'b1;
    #32;
  endtask
endmodule

// *** tws_pkg.sv ***
// Package with register map, field positions and encodings of the two-wire status block
package tws_pkg;
  // Register byte addresses (APB, one word each)
  localparam logic [7:0] ADDR_STATUS  = 8'h14;  // master_flag_status, index 0x05
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // enables, ack action, irq enables
  localparam logic [7:0] ADDR_TARGET  = 8'h04;  // master_target_reg
  localparam logic [7:0] ADDR_BYTE    = 8'h08;  // master_byte_reg
  localparam logic [7:0] ADDR_CMD     = 8'h0c;  // master_control_second command
  localparam logic [7:0] ADDR_SSTAT   = 8'h10;  // slave collision / data / addr-stop
  localparam logic [7:0] STATUS_INDEX = 8'h05;

  // Status field positions
  localparam int BIT_RIF   = 7;
  localparam int BIT_WIF   = 6;
  localparam int BIT_HOLD  = 5;
  localparam int BIT_ACK   = 4;
  localparam int BIT_ARB   = 3;
  localparam int BIT_BERR  = 2;
  // Slave status positions
  localparam int BIT_SLAVE_COLLISION_FLAG  = 3;
  localparam int BIT_SDIF  = 1;
  localparam int BIT_SAPIF = 0;
  // Control field positions
  localparam int BIT_EN    = 0;
  localparam int BIT_READ_IRQ_ENABLE  = 1;
  localparam int BIT_WRITE_IRQ_ENABLE  = 2;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] ACK_NONE = 2'h0;

  // Bus state encoding
  typedef enum logic [1:0] {
    BS_UNKNOWN = 2'h0,
    BS_IDLE    = 2'h1,
    BS_OWNER   = 2'h2,
    BS_BUSY    = 2'h3
  } tws_bus_e;

  // Events from the shifting engine
  typedef struct packed {
    logic rd_done;     // Master byte read finished
    logic wr_done;     // Address or byte write finished
    logic arb_lost;    // Arbitration lost
    logic ack_valid;   // Acknowledge bit sampled
    logic ack_nack;    // Sampled acknowledge value
    logic addr_acked;  // Address byte was acknowledged
    logic own_start;   // This master issued a Start
    logic hold;        // Master stretching SCL
    logic slv_slave_collision_flag;    // Slave could not put high bit
    logic slv_done;    // Slave transaction ended
  } tws_evt_s;

  // Register access strobes to the shifting engine
  typedef struct packed {
    logic read_start;  // Start a master byte read
    logic tgt_wr;      // Target register written
    logic byte_wr;     // Byte register written
    logic cmd_wr;      // Valid command written
  } tws_acc_s;
endpackage

// *** tws_status.sv ***
// Status and flag logic of the two-wire master with APB register access
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
// What this block does
// (R1) Read-done set on clean master byte read
// (R2) Read starts on byte read or target write with bit 0 set
// (R3) Read-done only after address was acknowledged
// (R4) Write-done set on any address/byte write
// (R5) Writing one clears the status flags
// (R6) Stretch flag shows master holding SCL
// (R7) Register accesses also clear stretch flag
// (R8) Same accesses clear read, write, arbitration
// (R9) Last acknowledge bit kept, read only
// (R10) Arbitration loss sets its flag
// (R11) Software rewrites target after losing bus
// (R12) Target write clears arbitration flag
// (R13) Illegal Start/Stop sets bus fault
// (R14) Target write clears bus fault
// (R15) Fault detection needs enable, fast clock
// (R16) Bus state encoded unknown/idle/owner/busy
// (R17) Unknown after reset, re-enable, disabled
// (R18) Writing one forces idle only
// (R19) Read and write irq from flags
// (R20) Slave collision sets flag, stops low drive
// (R21) Slave data flag set after collision
// (R22) Collision clears by one or Start
// (R23) Start/Stop move the bus state
module tws_status (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Bus lines and engine
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire tws_pkg::tws_evt_s evt,
  output tws_pkg::tws_acc_s      acc_ff,
  output logic                   slave_sda_off_ff,
  // Interrupt requests
  output logic                   read_irq_ff,
  output logic                   write_irq_ff
);
  // Register state
  logic       rif_ff, wif_ff, hold_ff, ack_ff, arb_ff, berr_ff;
  logic       slave_collision_flag_ff, sdif_ff, sapif_ff;
  logic       en_ff, read_irq_enable_ff, write_irq_enable_ff;
  logic [1:0] ack_action_ff;
  tws_pkg::tws_bus_e bus_ff;
  logic       scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff, scl_p_ff, sda_p_ff;
  logic       just_started_ff;
  logic       read_pend_ff;
  logic       rd_ok_ff;
  logic       hold_prev_ff;
  logic       berr_set;

  // APB decode
  logic acc, wr, rd, w_stat, w_ctrl, w_tgt, w_byte, w_cmd, w_sst, r_byte;
  logic start_det, stop_det, clr_access;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign w_stat = wr && paddr == tws_pkg::ADDR_STATUS;
  assign w_ctrl = wr && paddr == tws_pkg::ADDR_CTRL;
  assign w_tgt  = wr && paddr == tws_pkg::ADDR_TARGET;
  assign w_byte = wr && paddr == tws_pkg::ADDR_BYTE;
  assign w_cmd  = wr && paddr == tws_pkg::ADDR_CMD && pwdata[1:0] != 2'h0;
  assign w_sst  = wr && paddr == tws_pkg::ADDR_SSTAT;
  assign r_byte = rd && paddr == tws_pkg::ADDR_BYTE;
  // Indirect clearing set shared by several flags
  assign clr_access = w_tgt || w_byte || w_cmd
                      || (r_byte && ack_action_ff != tws_pkg::ACK_NONE);  // [R7] [R8]

  // Zero-wait APB answer, unmapped reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          tws_pkg::ADDR_STATUS: prdata <= {24'h0, rif_ff, wif_ff, hold_ff, ack_ff, arb_ff, berr_ff, bus_ff};
          tws_pkg::ADDR_CTRL:   prdata <= {27'h0, ack_action_ff, write_irq_enable_ff, read_irq_enable_ff, en_ff};
          tws_pkg::ADDR_SSTAT:  prdata <= {28'h0, slave_collision_flag_ff, 1'b0, sdif_ff, sapif_ff};
          default:              prdata <= 32'h0;
        endcase
      end
    end
  end

  // Access phase ends one cycle after setup: pready rises in the access cycle
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 1'b0;
      read_irq_enable_ff <= 1'b0;
      write_irq_enable_ff <= 1'b0;
      ack_action_ff <= tws_pkg::ACK_NONE;
    end else if (w_ctrl && pready) begin
      en_ff <= pwdata[tws_pkg::BIT_EN];
      read_irq_enable_ff <= pwdata[tws_pkg::BIT_READ_IRQ_ENABLE];
      write_irq_enable_ff <= pwdata[tws_pkg::BIT_WRITE_IRQ_ENABLE];
      ack_action_ff <= pwdata[4:3];
    end
  end

  // Engine strobes, one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= '0;
    end else begin
      acc_ff.read_start <= pready && (r_byte || (w_tgt && pwdata[0]));  // [R2]
      acc_ff.tgt_wr     <= pready && w_tgt;
      acc_ff.byte_wr    <= pready && w_byte;
      acc_ff.cmd_wr     <= pready && w_cmd;
    end
  end

  // Read pending tracks a started read; rd_ok_ff tracks whether address was acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_pend_ff <= 1'b0;
      rd_ok_ff <= 1'b0;
    end else begin
      if (evt.ack_valid)
        rd_ok_ff <= evt.addr_acked;  // [R3]
      if (acc_ff.read_start)
        read_pend_ff <= 1'b1;
      else if (evt.rd_done || evt.arb_lost || berr_set)
        read_pend_ff <= 1'b0;
    end
  end

  // Line synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      scl_p_ff <= 1'b1;
      sda_p_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      scl_p_ff <= scl_s_ff;
      sda_p_ff <= sda_s_ff;
    end
  end
  assign start_det = scl_s_ff && scl_p_ff && sda_p_ff && !sda_s_ff;
  assign stop_det  = scl_s_ff && scl_p_ff && !sda_p_ff && sda_s_ff;

  // Start directly followed by Stop is illegal; the detector only runs while enabled
  assign berr_set = en_ff && stop_det && just_started_ff;  // [R13] [R15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      just_started_ff <= 1'b0;
    else if (start_det)
      just_started_ff <= 1'b1;
    else if (!scl_s_ff)
      just_started_ff <= 1'b0;
  end

  // Master flags: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rif_ff  <= 1'b0;
      wif_ff  <= 1'b0;
      arb_ff  <= 1'b0;
      berr_ff <= 1'b0;
      ack_ff  <= 1'b0;
    end else begin
      if (evt.rd_done && read_pend_ff && rd_ok_ff && !evt.arb_lost && !berr_set)
        rif_ff <= 1'b1;  // [R1] [R3]
      else if ((pready && w_stat && pwdata[tws_pkg::BIT_RIF]) || (pready && clr_access))
        rif_ff <= 1'b0;  // [R5] [R8]
      if (evt.wr_done)
        wif_ff <= 1'b1;  // [R4]
      else if ((pready && w_stat && pwdata[tws_pkg::BIT_WIF]) || (pready && clr_access))
        wif_ff <= 1'b0;  // [R5] [R8]
      if (evt.arb_lost)
        arb_ff <= 1'b1;  // [R10]
      else if ((pready && w_stat && pwdata[tws_pkg::BIT_ARB]) || (pready && clr_access))
        arb_ff <= 1'b0;  // [R5] [R8] [R12]
      if (berr_set)
        berr_ff <= 1'b1;  // [R13]
      else if (pready && ((w_stat && pwdata[tws_pkg::BIT_BERR]) || w_tgt))
        berr_ff <= 1'b0;  // [R5] [R14]
      if (evt.ack_valid)
        ack_ff <= evt.ack_nack;  // [R9]
    end
  end

  // Stretch flag rises when the engine starts holding SCL and falls when it lets go;
  // a clearing access drops it while the hold lasts, and a fresh hold wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff      <= 1'b0;
      hold_prev_ff <= 1'b0;
    end else begin
      hold_prev_ff <= evt.hold;
      if (evt.hold && !hold_prev_ff)
        hold_ff <= 1'b1;  // [R6]
      else if (!evt.hold || (pready && ((w_stat && pwdata[tws_pkg::BIT_HOLD]) || clr_access)))
        hold_ff <= 1'b0;  // [R5] [R7]
    end
  end

  // Bus state tracker
  logic en_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ff <= tws_pkg::BS_UNKNOWN;  // [R17]
      en_prev_ff <= 1'b0;
    end else begin
      en_prev_ff <= en_ff;
      if (!en_ff || !en_prev_ff)
        bus_ff <= tws_pkg::BS_UNKNOWN;  // [R17]
      else if (pready && w_stat && pwdata[1:0] == 2'h1)
        bus_ff <= tws_pkg::BS_IDLE;  // [R18]
      else if (stop_det)
        bus_ff <= tws_pkg::BS_IDLE;  // [R23] [R16]
      else if (evt.own_start)
        bus_ff <= tws_pkg::BS_OWNER;  // [R23]
      else if (start_det && bus_ff != tws_pkg::BS_OWNER)
        bus_ff <= tws_pkg::BS_BUSY;  // [R23]
    end
  end

  // Slave collision and related flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_collision_flag_ff <= 1'b0;
      sdif_ff <= 1'b0;
      sapif_ff <= 1'b0;
      slave_sda_off_ff <= 1'b0;
    end else begin
      if (evt.slv_slave_collision_flag)
        slave_collision_flag_ff <= 1'b1;  // [R20]
      else if (start_det || (pready && w_sst && pwdata[tws_pkg::BIT_SLAVE_COLLISION_FLAG]))
        slave_collision_flag_ff <= 1'b0;  // [R22]
      slave_sda_off_ff <= evt.slv_slave_collision_flag || (slave_collision_flag_ff && !start_det);  // [R20]
      if (evt.slv_done && (slave_collision_flag_ff || evt.slv_slave_collision_flag))
        sdif_ff <= 1'b1;  // [R21]
      else if (pready && w_sst && pwdata[tws_pkg::BIT_SDIF])
        sdif_ff <= 1'b0;
      if (stop_det)
        sapif_ff <= 1'b1;
      else if (pready && w_sst && pwdata[tws_pkg::BIT_SAPIF])
        sapif_ff <= 1'b0;
    end
  end

  // Interrupt requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_irq_ff <= 1'b0;
      write_irq_ff <= 1'b0;
    end else begin
      read_irq_ff  <= rif_ff && read_irq_enable_ff;  // [R19]
      write_irq_ff <= wif_ff && write_irq_enable_ff;  // [R19]
    end
  end

  // Assertions
  property p_wif_set;
    @(posedge pclk) disable iff (!presetn) evt.wr_done |=> wif_ff;
  endproperty
  a_wif_set: assert property (p_wif_set) else $error("write flag not set"); // [R4]
  property p_arb_set;
    @(posedge pclk) disable iff (!presetn) evt.arb_lost |=> arb_ff;
  endproperty
  a_arb_set: assert property (p_arb_set) else $error("arbitration flag not set"); // [R10]
  property p_arb_clr;
    @(posedge pclk) disable iff (!presetn) (pready && w_tgt && !evt.arb_lost) |=> !arb_ff;
  endproperty
  a_arb_clr: assert property (p_arb_clr) else $error("arbitration flag not cleared"); // [R12]
  property p_berr_clr;
    @(posedge pclk) disable iff (!presetn) (pready && w_tgt && !berr_set) |=> !berr_ff;
  endproperty
  a_berr_clr: assert property (p_berr_clr) else $error("bus fault not cleared"); // [R14]
  property p_unknown;
    @(posedge pclk) disable iff (!presetn) !en_ff |=> bus_ff == tws_pkg::BS_UNKNOWN;
  endproperty
  a_unknown: assert property (p_unknown) else $error("state not unknown when off"); // [R17]
  property p_idle;
    @(posedge pclk) disable iff (!presetn) (en_ff && en_prev_ff && pready && w_stat && pwdata[1:0] == 2'h1) |=> bus_ff == tws_pkg::BS_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle force failed"); // [R18]
  property p_irq;
    @(posedge pclk) disable iff (!presetn) (wif_ff && write_irq_enable_ff) |=> write_irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("write irq missing"); // [R19]
  property p_slave_collision_flag;
    @(posedge pclk) disable iff (!presetn) evt.slv_slave_collision_flag |=> slave_collision_flag_ff && slave_sda_off_ff;
  endproperty
  a_slave_collision_flag: assert property (p_slave_collision_flag) else $error("collision not taken"); // [R20]
  c_read: cover property (@(posedge pclk) disable iff (!presetn) rif_ff ##1 !rif_ff);
  c_owner: cover property (@(posedge pclk) disable iff (!presetn) bus_ff == tws_pkg::BS_OWNER);
  c_berr: cover property (@(posedge pclk) disable iff (!presetn) berr_ff);
  c_hold: cover property (@(posedge pclk) disable iff (!presetn) hold_ff ##1 !hold_ff);
  c_slave_collision_flag: cover property (@(posedge pclk) disable iff (!presetn) slave_collision_flag_ff && slave_sda_off_ff);

  // Read path checks
  property p_rif_set;
    @(posedge pclk) disable iff (!presetn)
      evt.rd_done && read_pend_ff && rd_ok_ff && !evt.arb_lost && !berr_set |=> rif_ff;
  endproperty
  a_rif_set: assert property (p_rif_set) else $error("read flag not set"); // [R1]
  property p_rif_ack;
    @(posedge pclk) disable iff (!presetn) !rif_ff && !rd_ok_ff |=> !rif_ff;
  endproperty
  a_rif_ack: assert property (p_rif_ack) else $error("read flag without acknowledged address"); // [R3]
  property p_rd_start;
    @(posedge pclk) disable iff (!presetn) pready && r_byte |=> acc_ff.read_start;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read not started"); // [R2]
  // Clearing and acknowledge checks
  property p_wif_clr;
    @(posedge pclk) disable iff (!presetn) pready && w_stat && pwdata[tws_pkg::BIT_WIF] && !evt.wr_done |=> !wif_ff;
  endproperty
  a_wif_clr: assert property (p_wif_clr) else $error("write flag not cleared by one"); // [R5]
  property p_hold_clr;
    @(posedge pclk) disable iff (!presetn) pready && clr_access && !(evt.hold && !hold_prev_ff) |=> !hold_ff;
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("stretch flag not cleared by access"); // [R7]
  property p_rif_clr;
    @(posedge pclk) disable iff (!presetn) pready && clr_access && !evt.rd_done |=> !rif_ff;
  endproperty
  a_rif_clr: assert property (p_rif_clr) else $error("read flag not cleared by access"); // [R8]
  property p_ack;
    @(posedge pclk) disable iff (!presetn) evt.ack_valid |=> ack_ff == $past(evt.ack_nack);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge bit not kept"); // [R9]
  // Bus fault and line state checks
  property p_berr_set;
    @(posedge pclk) disable iff (!presetn) berr_set |=> berr_ff;
  endproperty
  a_berr_set: assert property (p_berr_set) else $error("bus fault not set"); // [R13]
  property p_berr_en;
    @(posedge pclk) disable iff (!presetn) !en_ff && !berr_ff |=> !berr_ff;
  endproperty
  a_berr_en: assert property (p_berr_en) else $error("bus fault while disabled"); // [R15]
  property p_owner;
    @(posedge pclk) disable iff (!presetn) en_ff && en_prev_ff && evt.own_start && !stop_det
      && !(pready && w_stat && pwdata[1:0] == 2'h1) |=> bus_ff == tws_pkg::BS_OWNER;
  endproperty
  a_owner: assert property (p_owner) else $error("own start did not take the bus"); // [R23]
  // Slave side and interrupt checks
  property p_slave_collision_flag_clr;
    @(posedge pclk) disable iff (!presetn) start_det && !evt.slv_slave_collision_flag |=> !slave_collision_flag_ff;
  endproperty
  a_slave_collision_flag_clr: assert property (p_slave_collision_flag_clr) else $error("collision not cleared by start"); // [R22]
  property p_sdif;
    @(posedge pclk) disable iff (!presetn) evt.slv_done && slave_collision_flag_ff |=> sdif_ff;
  endproperty
  a_sdif: assert property (p_sdif) else $error("slave data flag not set"); // [R21]
  property p_rirq;
    @(posedge pclk) disable iff (!presetn) rif_ff && read_irq_enable_ff |=> read_irq_ff;
  endproperty
  a_rirq: assert property (p_rirq) else $error("read irq missing"); // [R19]
endmodule

// *** tws_status_test.sv ***
// Self-checking bench of the two-wire status block
`timescale 1ns/1ns
module tws_status_test;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  logic              scl;
  logic              sda;
  tws_pkg::tws_evt_s evt;
  tws_pkg::tws_acc_s acc;
  logic              sda_off;
  logic              rd_irq;
  logic              wr_irq;
  logic [31:0]       r;
  logic              rerr;
  int                n_mismatch;
  int                samples_checked;
  int                n_rs = 0;
  int                n_tw = 0;
  int                n_bw = 0;
  int                n_cw = 0;
  logic [7:0]        clr_a [4];
  logic              clr_w [4];

  tws_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda), .evt(evt), .acc_ff(acc), .slave_sda_off_ff(sda_off),
    .read_irq_ff(rd_irq), .write_irq_ff(wr_irq));
  tws_line_model u_line (.scl(scl), .sda(sda));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Counts engine strobes
  always @(posedge pclk) begin
    if (acc.read_start === 1'b1) n_rs <= n_rs + 1;
    if (acc.tgt_wr === 1'b1) n_tw <= n_tw + 1;
    if (acc.byte_wr === 1'b1) n_bw <= n_bw + 1;
    if (acc.cmd_wr === 1'b1) n_cw <= n_cw + 1;
  end

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) n_mismatch++;
    r    = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read a register and compare the masked low byte
  task automatic rs(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(r[7:0] & m, e);
  endtask
  // Engine events: rd,wr,arb,ackv,nack,aack,own,hold,slave_collision_flag,sdone
  task automatic drv(input logic [9:0] v);
    @(posedge pclk);
    evt <= tws_pkg::tws_evt_s'(v);
  endtask
  task automatic pulse(input logic [9:0] v);
    drv(v);
    drv(10'h000);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evt = '0;
    clr_a = '{tws_pkg::ADDR_TARGET, tws_pkg::ADDR_BYTE, tws_pkg::ADDR_CMD, tws_pkg::ADDR_BYTE};
    clr_w = '{1'b1, 1'b1, 1'b1, 1'b0};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rs(tws_pkg::ADDR_STATUS, 8'hff, tws_pkg::STATUS_RESET);
    pulse(10'h200);
    apb(1'b1, tws_pkg::ADDR_STATUS, 32'h1);
    rs(tws_pkg::ADDR_STATUS, 8'hff, 8'h00);
    apb(1'b1, tws_pkg::ADDR_CTRL, 32'h1);
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h00);
    apb(1'b1, tws_pkg::ADDR_STATUS, 32'h3);
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h00);
    apb(1'b1, tws_pkg::ADDR_STATUS, 32'h1);
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h01);
    apb(1'b1, tws_pkg::ADDR_STATUS, 32'h2);
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h01);
    pulse(10'h008);
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h02);
    u_line.stop_c();
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h01);
    u_line.start_c();
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h03);
    u_line.stop_c();
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h01);
    u_line.fault_c();
    rs(tws_pkg::ADDR_STATUS, 8'h04, 8'h04);
    apb(1'b1, tws_pkg::ADDR_TARGET, 32'h0);
    rs(tws_pkg::ADDR_STATUS, 8'h04, 8'h00);
    apb(1'b1, tws_pkg::ADDR_TARGET, 32'h1);
    apb(1'b0, tws_pkg::ADDR_BYTE, 32'h0);
    repeat (2) @(posedge pclk);
    chk(8'(n_rs), 8'h02);
    // Set read, write, stretch and arbitration flags, then clear by writing ones
    pulse(10'h050);
    pulse(10'h210);
    pulse(10'h180);
    drv(10'h004);
    rs(tws_pkg::ADDR_STATUS, 8'he8, 8'he8);
    apb(1'b1, tws_pkg::ADDR_STATUS, 32'h80);
    rs(tws_pkg::ADDR_STATUS, 8'he8, 8'h68);
    apb(1'b1, tws_pkg::ADDR_STATUS, 32'h68);
    rs(tws_pkg::ADDR_STATUS, 8'he8, 8'h00);
    drv(10'h000);
    // An invalid command leaves the flags alone
    apb(1'b1, tws_pkg::ADDR_CTRL, 32'h09);
    apb(1'b0, tws_pkg::ADDR_BYTE, 32'h0);
    pulse(10'h200);
    pulse(10'h180);
    apb(1'b1, tws_pkg::ADDR_CMD, 32'h0);
    rs(tws_pkg::ADDR_STATUS, 8'hc8, 8'hc8);
    // Each clearing access in turn
    for (int i = 0; i < 4; i++) begin
      pulse(10'h010);
      pulse(10'h390);
      drv(10'h004);
      apb(clr_w[i], clr_a[i], 32'h1);
      rs(tws_pkg::ADDR_STATUS, 8'he8, 8'h00);
      drv(10'h000);
    end
    chk({2'(n_tw), 2'(n_bw), 2'(n_cw), 2'b00}, 8'hd4);
    pulse(10'h060);
    apb(1'b1, tws_pkg::ADDR_STATUS, 32'h0);
    rs(tws_pkg::ADDR_STATUS, 8'h10, 8'h10);
    pulse(10'h040);
    rs(tws_pkg::ADDR_STATUS, 8'h10, 8'h00);
    // Interrupt requests follow flag and enable
    apb(1'b1, tws_pkg::ADDR_CTRL, 32'h07);
    pulse(10'h050);
    pulse(10'h210);
    repeat (3) @(posedge pclk);
    #1;
    chk({6'h0, rd_irq, wr_irq}, 8'h02);
    pulse(10'h100);
    repeat (3) @(posedge pclk);
    #1;
    chk({6'h0, rd_irq, wr_irq}, 8'h03);
    apb(1'b1, tws_pkg::ADDR_CTRL, 32'h01);
    repeat (3) @(posedge pclk);
    #1;
    chk({6'h0, rd_irq, wr_irq}, 8'h00);
    // Slave collision, data flag and clearing
    pulse(10'h002);
    rs(tws_pkg::ADDR_SSTAT, 8'h08, 8'h08);
    chk({7'h0, sda_off}, 8'h01);
    pulse(10'h001);
    rs(tws_pkg::ADDR_SSTAT, 8'h0a, 8'h0a);
    apb(1'b1, tws_pkg::ADDR_SSTAT, 32'h8);
    rs(tws_pkg::ADDR_SSTAT, 8'h08, 8'h00);
    pulse(10'h002);
    u_line.start_c();
    rs(tws_pkg::ADDR_SSTAT, 8'h08, 8'h00);
    u_line.stop_c();
    rs(8'h20, 8'hff, 8'h00);
    chk({7'h0, rerr}, 8'h00);
    apb(1'b1, tws_pkg::ADDR_CTRL, 32'h0);
    rs(tws_pkg::ADDR_STATUS, 8'h03, 8'h00);
    summarize();
  end
endmodule
